// ### dv/spi_control_status_tb_top.sv
/* self-checking bench: register model, master and slave traffic, flags.
 * assumes: spictl_far_end plays the far side and resolves the shared wires. */
`timescale 1ns/10ps

module spi_control_status_tb_top;
    // ****************************
    // stimulus and checking
    // ****************************
    logic clk, rst, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, int_enable, irq;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [2:0] sfr_bit_idx;
    logic link_sck, mosi_in, miso_in, nss_in;
    spictl_pkg::spictl_pins_t pins;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] a, b, c, r, t, m, got;
    logic [7:0] exp_q[$];

    spictl_core #(.HALF(4)) dut
    (
        .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_bit_wr(sfr_bit_wr), .sfr_bit_idx(sfr_bit_idx), .sfr_bit_val(sfr_bit_val),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .int_enable(int_enable), .irq(irq),
        .link_sck(link_sck), .mosi_in(mosi_in), .miso_in(miso_in), .nss_in(nss_in), .pins(pins)
    );
    spictl_far_end far
    (
        .pins(pins), .link_sck(link_sck), .mosi_in(mosi_in), .miso_in(miso_in), .nss_in(nss_in)
    );

    // 50 ns system clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // cycle ceiling against hangs
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail = n_fail + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // register bus: one-cycle strobes launched after an edge
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= ad;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask

    task automatic bw(input logic [2:0] i, input logic v);
        @(posedge clk);
        sfr_bit_idx <= i;
        sfr_bit_val <= v;
        sfr_bit_wr <= 1'b1;
        @(posedge clk);
        sfr_bit_wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge clk);
        sfr_addr <= ad;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1;
        chk(sfr_rdata, exp);
    endtask

    // main sequence
    initial
    begin
        rst = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_bit_wr = 1'b0;
        sfr_bit_idx = 3'h0;
        sfr_bit_val = 1'b0;
        sfr_rd = 1'b0;
        int_enable = 1'b0;
        #1 rst = 1'b1; // a real rising edge, so the link-side flops clear too
        a = 8'($urandom(32'h4c8e));
        b = 8'($urandom());
        c = 8'($urandom());
        r = 8'($urandom());
        t = 8'($urandom());
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdchk(8'hf8, 8'h06);
        rdchk(8'ha1, 8'h00);
        rdchk(8'h55, 8'h00);
        bw(3'h0, 1'b1);
        rdchk(8'hf8, 8'h07);
        bw(3'h1, 1'b0);
        rdchk(8'hf8, 8'h07);
        wr(8'hf8, 8'hf4);
        rdchk(8'hf8, 8'hf6);
        @(posedge clk);
        int_enable <= 1'b1;
        for (int i = 7; i >= 4; i--)
        begin
            #1 chk({7'h0, irq}, 8'h01);
            bw(i[2:0], 1'b0);
        end
        #1 chk({7'h0, irq}, 8'h00);
        for (int s = 0; s < 4; s++)
        begin
            wr(8'hf8, 8'(s * 4 + 1));
            rdchk(8'hf8, 8'(s * 4 + 3));
            chk({6'h0, pins.nss_oe_n, pins.slave_select_pin | pins.nss_oe_n},
                (s > 1) ? {7'h0, s[0]} : 8'h03);
        end
        // master: held while disabled, second byte queues, third collides
        far.reply = r;
        wr(8'ha1, 8'h40);
        wr(8'hf8, 8'h08);
        wr(8'ha3, a);
        repeat (20) @(posedge clk);
        rdchk(8'hf8, 8'h08);
        wr(8'hf8, 8'h09);
        repeat (3) @(posedge clk);
        wr(8'ha3, b);
        rdchk(8'hf8, 8'h09);
        wr(8'ha3, c);
        exp_q.push_back(a);
        exp_q.push_back(b);
        repeat (160) @(posedge clk);
        rdchk(8'ha1, 8'h40);
        rdchk(8'hf8, 8'hcb);
        rdchk(8'ha3, r);
        chk({7'h0, irq}, 8'h01);
        chk(8'(far.got_q.size()), 8'h02);
        for (int k = 0; k < 2; k++)
            chk(far.got_q[k], exp_q[k]);
        @(posedge clk);
        int_enable <= 1'b0;
        #1 chk({7'h0, irq}, 8'h00);
        // mode fault: master, four-wire input mode, select pulled low
        wr(8'hf8, 8'h05);
        @(posedge clk);
        far.sel_n <= 1'b0;
        repeat (6) @(posedge clk);
        rdchk(8'hf8, 8'h27);
        @(posedge clk);
        far.sel_n <= 1'b1;
        repeat (4) @(posedge clk);
        bw(3'h5, 1'b0);
        rdchk(8'hf8, 8'h07);
        // slave frames: stale tx byte repeats, unread rx byte overruns
        wr(8'ha1, 8'h00);
        wr(8'ha3, t);
        for (int k = 0; k < 3; k++)
        begin
            m = 8'($urandom());
            far.xfer(m, got);
            repeat (10) @(posedge clk);
            chk(got, t);
            rdchk(8'hf8, (k == 2) ? 8'h97 : 8'h87);
            if (k == 0)
                rdchk(8'ha3, m);
        end
        give_verdict();
    end
endmodule

// ### dv/spictl_core_properties.sv
/* checker: port-level timing relations of spictl_core.
 * assumes: bound into spictl_core; every relation is sampled on clk. */
`timescale 1ns/10ps

module spictl_core_properties
#(
    parameter int HALF = 4
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_bit_wr,
    input wire logic [2:0] sfr_bit_idx,
    input wire logic sfr_bit_val,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic int_enable,
    input wire logic irq,
    input wire spictl_pkg::spictl_pins_t pins
);
    // ****************************
    // helper logic and assertions
    // ****************************
    logic sck_d_reg;
    logic [7:0] run_reg;
    logic quiet;

    // cycles since the serial clock last changed
    always_ff @(posedge clk)
    begin
        sck_d_reg <= pins.sck;
        run_reg <= (rst || pins.sck != sck_d_reg) ? 8'h00 : run_reg + 8'h01;
    end
    assign quiet = !sfr_wr && !sfr_bit_wr; // no register write this cycle

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_RESET_QUIET:
        assert property (disable iff (1'b0) rst |=> !irq && sfr_rdata == 8'h00 && pins.sck_oe_n
            && pins.mosi_oe_n && pins.miso_oe_n && pins.nss_oe_n) else $error("reset state wrong");
    AST_IRQ_MASK:
        assert property (!int_enable |-> !irq) else $error("irq high while masked");
    AST_IRQ_HOLD:
        assert property (irq && quiet ##1 int_enable |-> irq) else $error("flag lost by hardware");
    AST_UNMAPPED_ZERO:
        assert property (sfr_rd && !(sfr_addr inside {8'hf8, 8'ha3, 8'ha1}) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RDATA_HOLD:
        assert property (!sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
    AST_SSM_PIN:
        assert property (sfr_rd && sfr_addr == 8'hf8 && quiet ##1 quiet && !sfr_rd |=>
            pins.nss_oe_n == !(sfr_rdata[3] && sfr_rdata[0])
            && (pins.nss_oe_n || pins.slave_select_pin == sfr_rdata[2])) else $error("select pin mismatch");
    AST_SCK_HIGH_TIME:
        assert property (sck_d_reg && !pins.sck && !pins.sck_oe_n |-> run_reg == 8'(HALF - 1))
        else $error("serial clock high time wrong");
    AST_ONE_DIRECTION:
        assert property (!pins.miso_oe_n |-> pins.mosi_oe_n && pins.sck_oe_n)
        else $error("master and slave drive together");
    AST_BIT_WRITE_EN:
        assert property (sfr_bit_wr && sfr_bit_idx == 3'h0 && !sfr_wr ##1 quiet ##1
            sfr_rd && sfr_addr == 8'hf8 && quiet |=> sfr_rdata[0] == $past(sfr_bit_val, 3))
        else $error("bit write not applied");
    AST_BYTE_WRITE_CTL:
        assert property (sfr_wr && sfr_addr == 8'hf8 && !sfr_bit_wr ##1 quiet ##1
            sfr_rd && sfr_addr == 8'hf8 && quiet |=> sfr_rdata[3:2] == $past(sfr_wdata[3:2], 3)
            && sfr_rdata[0] == $past(sfr_wdata[0], 3)) else $error("control write not applied");

    COV_MASTER_BIT: cover property (sck_d_reg && !pins.sck && !pins.sck_oe_n);
    COV_IRQ: cover property ($rose(irq));
    COV_SLAVE_DRIVE: cover property (!pins.miso_oe_n);
endmodule

bind spictl_core spictl_core_properties #(.HALF(HALF)) u_props
(
    .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_idx(sfr_bit_idx), .sfr_bit_val(sfr_bit_val),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .int_enable(int_enable), .irq(irq), .pins(pins)
);

// ### dv/spictl_far_end.sv
/* far-side model: mode 0 slave for master traffic, mode 0 master for slave frames.
 * assumes: pins come from spictl_core; the link clock only runs inside frames. */
`timescale 1ns/10ps

module spictl_far_end
(
    input wire spictl_pkg::spictl_pins_t pins,
    output logic link_sck,
    output logic mosi_in,
    output logic miso_in,
    output logic nss_in
);
    // ****************************
    // wires, slave side, frames
    // ****************************
    logic sel_n = 1'b1;
    logic ext_sck = 1'b0;
    logic mosi_drv = 1'b0;
    logic [7:0] reply = 8'h00;
    logic [7:0] sh = 8'h00;
    int nbits = 0;
    logic [7:0] got_q[$];

    // shared wires: a driving enable wins, else the far side
    assign link_sck = pins.sck_oe_n ? ext_sck : pins.sck;
    assign mosi_in = pins.mosi_oe_n ? mosi_drv : pins.mosi;
    assign nss_in = pins.nss_oe_n ? sel_n : pins.slave_select_pin;
    assign miso_in = !pins.miso_oe_n ? pins.miso : (nss_in ? ~reply[7] : reply[7]);

    // capture master data on the rising edge
    always @(posedge pins.sck)
    begin
        if (!pins.sck_oe_n)
        begin
            sh = {sh[6:0], pins.mosi};
            nbits = nbits + 1;
            if (nbits == 8)
            begin
                got_q.push_back(sh);
                nbits = 0;
            end
        end
    end

    // rotate the reply so every byte returns the same value
    always @(negedge pins.sck)
    begin
        if (!pins.sck_oe_n)
            reply = {reply[6:0], reply[7]};
    end

    // one frame at a 12 ns link period, clock idles low outside it
    task automatic xfer(input logic [7:0] m, output logic [7:0] got);
        sel_n = 1'b0;
        #200;
        for (int i = 7; i >= 0; i--)
        begin
            mosi_drv = m[i];
            #6;
            got[i] = miso_in;
            ext_sck = 1'b1;
            #6;
            ext_sck = 1'b0;
        end
        #200;
        sel_n = 1'b1;
        mosi_drv = ~mosi_drv; // released line shows no stale bit
    endtask
endmodule

// ### logic/spictl_core.sv
/*
 * serial port control/status core: control register, flags, master shifter
 * on the system clock and slave shifter on the external serial clock.
 * assumes: single-cycle sfr write/read strobes on clk; the serial clock
 * stands still while the slave is not selected; mode 0 framing.
 */
// How it works
// - each finished byte sets the done flag in bit 7, which only software clears.
// - a set done flag drives the interrupt request when interrupts are enabled.
// - a data write while a transfer is active and the transmit buffer is still full sets the collision flag in bit 6 until cleared.
// - select pin low with master on and select mode 01 sets the mode fault flag in bit 5.
// - in slave mode a byte finishing while the receive buffer is unread sets bit 4.
// - select mode 00 is three-wire, the select pin is not driven and does not gate the slave shifter.
// - select mode 01 is four-wire slave or multi-master with the pin as input, the reset value.
// - select mode 1x drives the select pin with the low mode bit.
// - writing the transmit buffer clears the read-only buffer empty bit 1.
// - moving the transmit buffer into the shifter sets buffer empty.
// - enable bit 0 turns the port off at 0 and on at 1 and resets to 0.
// - the control register sits at 0xf8 and accepts single-bit writes.
// - master enable selects master at 1 and slave at 0.
// - in master mode a data write loads the buffer and starts a byte; a read returns rx.
`timescale 1ns/10ps

module spictl_core
#(
    parameter int HALF = spictl_pkg::HALF_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_bit_wr,
    input wire logic [2:0] sfr_bit_idx,
    input wire logic sfr_bit_val,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic int_enable,
    output logic irq,
    input wire logic link_sck,
    input wire logic mosi_in,
    input wire logic miso_in,
    input wire logic nss_in,
    output spictl_pkg::spictl_pins_t pins
);

    // ************************************************
    // address decode helper
    // ************************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = (a == ref_a);
    endfunction

    // clk domain state
    logic [7:0] ctl_reg, ctl_next;
    logic master_en_reg, master_en_next;
    logic [7:0] tx_hold_reg, tx_hold_next;
    logic [7:0] rx_buf_reg, rx_buf_next;
    logic rx_full_reg, rx_full_next;
    logic [7:0] rdata_reg, rdata_next;
    spictl_pkg::spictl_state_t state_reg, state_next;
    logic [7:0] m_sh_reg, m_sh_next;
    logic [2:0] m_bit_reg, m_bit_next;
    logic [7:0] m_half_reg, m_half_next;
    logic sck_reg, sck_next;
    logic samp_reg, samp_next;
    logic miso_s1, miso_s2, nss_s1, nss_s2;
    logic done_s1, done_s2, done_s3, load_s1, load_s2, load_s3;

    // link domain state
    logic [2:0] sl_cnt_reg, sl_cnt_next;
    logic [6:0] sl_rx_reg, sl_rx_next;
    logic [7:0] sl_hold_reg, sl_hold_next;
    logic [7:0] sl_tx_reg, sl_tx_next;
    logic sl_done_tgl, sl_done_next, sl_load_tgl, sl_load_next;

    logic enabled, is_master, slave_on, sel_n, link_clr;
    logic ctl_wr, dat_wr, dat_rd, active, m_start, m_byte_end;
    logic sl_byte_evt, sl_load_evt;
    logic [1:0] ssm;
    logic [7:0] ctl_sw;

    assign enabled = ctl_reg[spictl_pkg::BIT_EN];
    assign is_master = master_en_reg;
    assign slave_on = enabled && !is_master;
    assign ssm = ctl_reg[spictl_pkg::BIT_SSM_HI:spictl_pkg::BIT_SSM_LO];
    assign ctl_wr = sfr_wr && hit(sfr_addr, spictl_pkg::ADDR_CTL);
    assign dat_wr = sfr_wr && hit(sfr_addr, spictl_pkg::ADDR_DAT);
    assign dat_rd = sfr_rd && hit(sfr_addr, spictl_pkg::ADDR_DAT);

    // ************************************************
    // pin input synchronisers
    // ************************************************
    always_ff @(posedge clk)
    begin
        miso_s1 <= miso_in;
        miso_s2 <= miso_s1;
        nss_s1 <= nss_in;
        nss_s2 <= nss_s1;
    end

    // ************************************************
    // slave shifter on the link clock
    // ************************************************
    // three-wire mode treats the slave as always selected
    assign sel_n = (ssm == spictl_pkg::SSM_3WIRE) ? 1'b0 : nss_in;
    assign link_clr = rst || sel_n || !slave_on;

    // next values of the link-side shifter
    always_comb
    begin
        sl_cnt_next = sl_cnt_reg + 3'h1;
        sl_rx_next = {sl_rx_reg[5:0], mosi_in};
        sl_hold_next = sl_hold_reg;
        sl_done_next = sl_done_tgl;
        sl_load_next = sl_load_tgl;
        sl_tx_next = {sl_tx_reg[6:0], 1'b0};
        if (sl_cnt_reg == 3'h0)
        begin
            sl_tx_next = {tx_hold_reg[6:0], 1'b0};
            sl_load_next = !sl_load_tgl;
        end
        if (sl_cnt_reg == spictl_pkg::LAST_BIT)
        begin
            sl_hold_next = {sl_rx_reg, mosi_in};
            sl_done_next = !sl_done_tgl;
        end
    end

    // bit counter restarts whenever the slave is deselected
    always_ff @(posedge link_sck or posedge link_clr)
    begin
        if (link_clr)
        begin
            sl_cnt_reg <= 3'h0;
            sl_rx_reg <= 7'h00;
            sl_tx_reg <= 8'h00;
        end
        else
        begin
            sl_cnt_reg <= sl_cnt_next;
            sl_rx_reg <= sl_rx_next;
            sl_tx_reg <= sl_tx_next;
        end
    end

    // event toggles survive deselection
    always_ff @(posedge link_sck or posedge rst)
    begin
        if (rst)
        begin
            sl_hold_reg <= 8'h00;
            sl_done_tgl <= 1'b0;
            sl_load_tgl <= 1'b0;
        end
        else
        begin
            sl_hold_reg <= sl_hold_next;
            sl_done_tgl <= sl_done_next;
            sl_load_tgl <= sl_load_next;
        end
    end

    // ************************************************
    // event crossing into the system clock
    // ************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_s3 <= 1'b0;
            load_s1 <= 1'b0;
            load_s2 <= 1'b0;
            load_s3 <= 1'b0;
        end
        else
        begin
            done_s1 <= sl_done_tgl;
            done_s2 <= done_s1;
            done_s3 <= done_s2;
            load_s1 <= sl_load_tgl;
            load_s2 <= load_s1;
            load_s3 <= load_s2;
        end
    end

    assign sl_byte_evt = (done_s2 ^ done_s3) && slave_on;
    assign sl_load_evt = (load_s2 ^ load_s3) && slave_on;

    // ************************************************
    // master sequencer
    // ************************************************
    assign m_start = enabled && is_master && (state_reg == spictl_pkg::SPICTL_IDLE)
        && !ctl_reg[spictl_pkg::BIT_TX_BUFFER_EMPTY];
    assign m_byte_end = (state_reg == spictl_pkg::SPICTL_SHIFT) && sck_reg
        && (m_half_reg == 8'(HALF - 1)) && (m_bit_reg == spictl_pkg::LAST_BIT);

    // next values of the master shifter
    always_comb
    begin
        state_next = state_reg;
        m_sh_next = m_sh_reg;
        m_bit_next = m_bit_reg;
        m_half_next = m_half_reg;
        sck_next = sck_reg;
        samp_next = samp_reg;
        unique case (state_reg)
            spictl_pkg::SPICTL_IDLE:
            begin
                sck_next = 1'b0;
                if (m_start)
                begin
                    m_sh_next = tx_hold_reg;
                    m_bit_next = 3'h0;
                    m_half_next = 8'h00;
                    state_next = spictl_pkg::SPICTL_SHIFT;
                end
            end
            spictl_pkg::SPICTL_SHIFT:
            begin
                if (m_half_reg != 8'(HALF - 1))
                begin
                    m_half_next = m_half_reg + 8'h01;
                end
                else
                begin
                    m_half_next = 8'h00;
                    sck_next = !sck_reg;
                    if (!sck_reg)
                    begin
                        samp_next = miso_s2; // sample on the rising edge
                    end
                    else
                    begin
                        m_sh_next = {m_sh_reg[6:0], samp_reg};
                        m_bit_next = m_bit_reg + 3'h1;
                        if (m_bit_reg == spictl_pkg::LAST_BIT)
                        begin
                            state_next = spictl_pkg::SPICTL_IDLE;
                        end
                    end
                end
                if (!enabled || !is_master)
                begin
                    state_next = spictl_pkg::SPICTL_IDLE;
                    sck_next = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= spictl_pkg::SPICTL_IDLE;
            m_sh_reg <= 8'h00;
            m_bit_reg <= 3'h0;
            m_half_reg <= 8'h00;
            sck_reg <= 1'b0;
            samp_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            m_sh_reg <= m_sh_next;
            m_bit_reg <= m_bit_next;
            m_half_reg <= m_half_next;
            sck_reg <= sck_next;
            samp_reg <= samp_next;
        end
    end

    // ************************************************
    // registers and flags
    // ************************************************
    // a transfer counts as active while shifting, pending, or selected as slave
    assign active = is_master
        ? ((state_reg == spictl_pkg::SPICTL_SHIFT) || !ctl_reg[spictl_pkg::BIT_TX_BUFFER_EMPTY])
        : (slave_on && !nss_s2);

    // software view of the control register after byte or bit writes
    always_comb
    begin
        ctl_sw = ctl_reg;
        if (ctl_wr)
        begin
            ctl_sw = sfr_wdata;
        end
        else if (sfr_bit_wr)
        begin
            ctl_sw[sfr_bit_idx] = sfr_bit_val;
        end
    end

    // next values of the register file; hardware sets win over clears
    always_comb
    begin
        ctl_next = ctl_sw;
        ctl_next[spictl_pkg::BIT_TX_BUFFER_EMPTY] = ctl_reg[spictl_pkg::BIT_TX_BUFFER_EMPTY];
        master_en_next = master_en_reg;
        tx_hold_next = tx_hold_reg;
        rx_buf_next = rx_buf_reg;
        rx_full_next = rx_full_reg;
        rdata_next = rdata_reg;
        if (sfr_wr && hit(sfr_addr, spictl_pkg::ADDR_CFG))
        begin
            master_en_next = sfr_wdata[spictl_pkg::BIT_CFG_MST];
        end
        if (dat_rd)
        begin
            rx_full_next = 1'b0;
        end
        if (m_start || sl_load_evt)
        begin
            ctl_next[spictl_pkg::BIT_TX_BUFFER_EMPTY] = 1'b1;
        end
        if (dat_wr && active && !ctl_reg[spictl_pkg::BIT_TX_BUFFER_EMPTY])
        begin
            ctl_next[spictl_pkg::BIT_WRITE_COLLISION_FLAG] = 1'b1;
        end
        else if (dat_wr)
        begin
            tx_hold_next = sfr_wdata;
            ctl_next[spictl_pkg::BIT_TX_BUFFER_EMPTY] = 1'b0;
        end
        if (enabled && is_master && !nss_s2 && (ssm == spictl_pkg::SSM_4WIRE_IN))
        begin
            ctl_next[spictl_pkg::BIT_MODE_FAULT_FLAG] = 1'b1;
        end
        if (m_byte_end)
        begin
            rx_buf_next = {m_sh_reg[6:0], samp_reg};
            rx_full_next = 1'b1;
            ctl_next[spictl_pkg::BIT_DONE] = 1'b1;
        end
        if (sl_byte_evt)
        begin
            rx_buf_next = sl_hold_reg;
            rx_full_next = 1'b1;
            ctl_next[spictl_pkg::BIT_DONE] = 1'b1;
            if (rx_full_reg)
            begin
                ctl_next[spictl_pkg::BIT_OVRN] = 1'b1;
            end
        end
        if (sfr_rd)
        begin
            rdata_next = 8'h00;
            if (hit(sfr_addr, spictl_pkg::ADDR_CTL))
            begin
                rdata_next = ctl_reg;
            end
            else if (dat_rd)
            begin
                rdata_next = rx_buf_reg;
            end
            else if (hit(sfr_addr, spictl_pkg::ADDR_CFG))
            begin
                rdata_next[spictl_pkg::BIT_CFG_BUSY] = active;
                rdata_next[spictl_pkg::BIT_CFG_MST] = master_en_reg;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctl_reg <= spictl_pkg::CTL_RESET;
            master_en_reg <= 1'b0;
            tx_hold_reg <= 8'h00;
            rx_buf_reg <= 8'h00;
            rx_full_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            ctl_reg <= ctl_next;
            master_en_reg <= master_en_next;
            tx_hold_reg <= tx_hold_next;
            rx_buf_reg <= rx_buf_next;
            rx_full_reg <= rx_full_next;
            rdata_reg <= rdata_next;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign sfr_rdata = rdata_reg;

    // interrupt follows any set flag while interrupts are enabled
    assign irq = int_enable && |(ctl_reg & spictl_pkg::FLAG_MASK);

    // pin drive: master owns sck and mosi, selected slave owns miso
    always_comb
    begin
        pins.sck = sck_reg;
        pins.sck_oe_n = !(enabled && is_master);
        pins.mosi = m_sh_reg[7];
        pins.mosi_oe_n = !(enabled && is_master);
        pins.miso = (sl_cnt_reg == 3'h0) ? tx_hold_reg[7] : sl_tx_reg[7];
        pins.miso_oe_n = !(slave_on && !sel_n);
        pins.slave_select_pin = ctl_reg[spictl_pkg::BIT_SSM_LO];
        pins.nss_oe_n = !(enabled && ssm[1]);
    end

endmodule

// ### logic/spictl_pkg.sv
/*
 * constants, states and pin carrier for the serial port control/status block.
 * assumes: an 8-bit special-function register bus on the system clock.
 */
package spictl_pkg;

    // ************************************************
    // register addresses
    // ************************************************
    localparam logic [7:0] ADDR_CTL = 8'hf8;
    localparam logic [7:0] ADDR_DAT = 8'ha3;
    localparam logic [7:0] ADDR_CFG = 8'ha1;

    // ************************************************
    // field positions and reset values
    // ************************************************
    localparam int BIT_DONE = 7;
    localparam int BIT_WRITE_COLLISION_FLAG = 6;
    localparam int BIT_MODE_FAULT_FLAG = 5;
    localparam int BIT_OVRN = 4;
    localparam int BIT_SSM_HI = 3;
    localparam int BIT_SSM_LO = 2;
    localparam int BIT_TX_BUFFER_EMPTY = 1;
    localparam int BIT_EN = 0;
    localparam int BIT_CFG_BUSY = 7;
    localparam int BIT_CFG_MST = 6;
    localparam logic [7:0] CTL_RESET = 8'h06;
    localparam logic [7:0] FLAG_MASK = 8'hf0;
    localparam logic [1:0] SSM_3WIRE = 2'h0;
    localparam logic [1:0] SSM_4WIRE_IN = 2'h1;

    // ************************************************
    // timing
    // ************************************************
    localparam int HALF_CYCLES = 4;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ************************************************
    // master sequencer states
    // ************************************************
    typedef enum logic [1:0] {
        SPICTL_IDLE = 2'b01,
        SPICTL_SHIFT = 2'b10
    } spictl_state_t;

    // ************************************************
    // pin drive bundle, enables low while driving
    // ************************************************
    typedef struct packed {
        logic sck;
        logic sck_oe_n;
        logic mosi;
        logic mosi_oe_n;
        logic miso;
        logic miso_oe_n;
        logic slave_select_pin;
        logic nss_oe_n;
    } spictl_pins_t;

endpackage
